// ==== rtl/cafbt_pkg.sv ====
// Package: register map, field layout and reset values for the CAN
// acceptance filter and bit timing block.
// Assumes 32-bit APB with one aligned word per register.
package cafbt_pkg;

  localparam int ID_W = 29;
  localparam int STD_W = 11;

  // Register byte offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_TIMING = 8'h04;
  localparam logic [7:0] OFF_FIRST_BUF = 8'h08;
  localparam logic [7:0] OFF_SECOND_BUF = 8'h0C;
  localparam logic [7:0] OFF_FIRST_ID = 8'h10;
  localparam logic [7:0] OFF_SECOND_ID = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK0 = 8'h20;
  localparam logic [7:0] OFF_MASK1 = 8'h24;
  localparam logic [7:0] OFF_FILTER0 = 8'h30;

  // Control register fields
  localparam int CTL_CONFIG_BIT = 0;
  localparam int CTL_ROLLOVER_BIT = 1;
  localparam logic [1:0] CTL_RESET = 2'h1;

  // Buffer control fields
  localparam int BUF_FULL_BIT = 3;
  localparam int BUF_EXT_BIT = 4;

  // Timing register fields
  localparam int TIM_PRESCALER_LSB = 0;
  localparam int TIM_PROP_LSB = 8;
  localparam int TIM_PHASE1_LSB = 12;
  localparam int TIM_PHASE2_LSB = 16;
  localparam logic [18:0] TIM_RESET = 19'h00000;

  // Filter hit codes for rollover
  localparam logic [2:0] HIT_ROLL_F0 = 3'h6;
  localparam logic [2:0] HIT_ROLL_F1 = 3'h7;

  // Least phase two length in quanta, minus one
  localparam logic [2:0] PHASE2_MIN_M1 = 3'h1;

  typedef enum {
    SEG_SYNC,
    SEG_PROP,
    SEG_PHASE1,
    SEG_PHASE2
  } cafbt_seg_t;

endpackage

// ==== rtl/cafbt_match_if.sv ====
// Interface: carries the identifier, mask and filter between the top
// and the matching leaf.
// Assumes a single sys_clk domain.
`timescale 1ns/1ns
interface cafbt_match_if;
  logic [cafbt_pkg::ID_W-1:0] ident;
  logic extended;
  logic [cafbt_pkg::ID_W-1:0] mask;
  logic [cafbt_pkg::ID_W-1:0] filter;
  logic hit;
  modport top (output ident, output extended, output mask, output filter, input hit);
  modport cmp (input ident, input extended, input mask, input filter, output hit);
endinterface

// ==== rtl/cafbt_match.sv ====
// Leaf: one acceptance filter compare against its mask.
// Assumes combinational use inside cafbt_top.
`timescale 1ns/1ns
module cafbt_match (
  cafbt_match_if.cmp mif
);
  logic [cafbt_pkg::ID_W-1:0] widthMask;
  logic [cafbt_pkg::ID_W-1:0] bitOk;

  always_comb begin
    widthMask = mif.extended ? {cafbt_pkg::ID_W{1'b1}} :
      {{(cafbt_pkg::ID_W-cafbt_pkg::STD_W){1'b0}}, {cafbt_pkg::STD_W{1'b1}}};
    bitOk = ~mif.mask | ~(mif.ident ^ mif.filter);
    mif.hit = &(bitOk | ~widthMask);
  end
endmodule // cafbt_match

// ==== rtl/cafbt_top.sv ====
// Top: CAN acceptance filtering into two receive buffers and bit time
// quantum and segment generation, with an APB register slave.
// Assumes a protocol engine that pulses msgValid with a complete
// assembly_buffer identifier, and APB master on sys_clk.
//
// Behaviour
// - Mask bit zero accepts that position
// - Mask bit one needs identifier equal filter
// - Complete message copied only on match
// - Filters 0-1 buffer zero, 2-5 buffer one
// - Buffer one hit code is filter number
// - Codes 000/001 in buffer one only rollover
// - Rolled filter 0/1 hits coded 110/111
// - Lowest numbered matching filter wins
// - Mask/filter writes only in configuration mode
// - Mask/filter read zero outside configuration mode
// - Bit split into four quantum segments
// - Quanta per bit programmable 8 to 25; the timing fields allow 5 to 25
// - Quantum is 2*(prescaler+1) oscillator periods
// - Sync segment one quantum, edge expected there
// - Stuff bits give edge every six bits
// - Timing syncs to rx edges, times transmit
// - Propagation segment 1-8 quanta, 3-bit field
// - Phase segments 1-8, phase two min 2
// - Timing writes only in configuration mode
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module cafbt_top #(
  parameter int NUM_FILTERS = 6
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic msgValid,
  input wire logic [cafbt_pkg::ID_W-1:0] msgIdent,
  input wire logic msgExtended,
  input wire logic canRx,
  output logic quantumTick,
  output logic samplePoint,
  output logic bitStart
);
  // ==========================================================
  // Register state
  logic [1:0] control;
  logic [1:0] next_control;
  logic [18:0] timing;
  logic [18:0] next_timing;
  logic [cafbt_pkg::ID_W-1:0] mask [2];
  logic [cafbt_pkg::ID_W-1:0] next_mask [2];
  logic [cafbt_pkg::ID_W-1:0] filter [NUM_FILTERS];
  logic [cafbt_pkg::ID_W-1:0] next_filter [NUM_FILTERS];
  logic [4:0] firstBuf;
  logic [4:0] next_firstBuf;
  logic [4:0] secondBuf;
  logic [4:0] next_secondBuf;
  logic [cafbt_pkg::ID_W-1:0] firstId;
  logic [cafbt_pkg::ID_W-1:0] next_firstId;
  logic [cafbt_pkg::ID_W-1:0] secondId;
  logic [cafbt_pkg::ID_W-1:0] next_secondId;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic rxMeta;
  logic canRxSync;
  logic rxPrev;

  logic cfgMode;
  logic wrEn;
  logic rdEn;
  logic [NUM_FILTERS-1:0] hits;

  assign cfgMode = control[cafbt_pkg::CTL_CONFIG_BIT];
  assign wrEn = psel && penable && pwrite && !pready;
  assign rdEn = psel && penable && !pwrite && !pready;

  // ==========================================================
  // Filter compare
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILTERS; gi++) begin : gen_cmp
      cafbt_match_if mif ();
      assign mif.ident = msgIdent;
      assign mif.extended = msgExtended;
      assign mif.mask = (gi < 2) ? mask[0] : mask[1];
      assign mif.filter = filter[gi];
      assign hits[gi] = mif.hit;
      cafbt_match u_match (
        .mif(mif)
      );
    end
  endgenerate

  // ==========================================================
  // Registers and acceptance
  always_comb begin
    logic [2:0] code;
    logic found0;
    logic found1;
    logic [7:0] fOff;
    code = 3'h0;
    found0 = 1'b0;
    found1 = 1'b0;
    fOff = 8'h00;
    next_control = control;
    next_timing = timing;
    next_mask = mask;
    next_filter = filter;
    next_firstBuf = firstBuf;
    next_secondBuf = secondBuf;
    next_firstId = firstId;
    next_secondId = secondId;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    next_prdata = 32'h00000000;

    // Lowest filter first, buffer zero group
    for (int i = 1; i >= 0; i--) begin
      if (hits[i]) begin
        found0 = 1'b1;
        code = 3'(i);
      end
    end
    if (!found0) begin
      for (int i = NUM_FILTERS - 1; i >= 2; i--) begin
        if (hits[i]) begin
          found1 = 1'b1;
          code = 3'(i);
        end
      end
    end

    if (msgValid && !cfgMode) begin
      if (found0 && !firstBuf[cafbt_pkg::BUF_FULL_BIT]) begin
        next_firstBuf = {msgExtended, 1'b1, code};
        next_firstId = msgIdent;
      end else if (found0 && control[cafbt_pkg::CTL_ROLLOVER_BIT]
                   && !secondBuf[cafbt_pkg::BUF_FULL_BIT]) begin
        next_secondBuf = {msgExtended, 1'b1,
          code[0] ? cafbt_pkg::HIT_ROLL_F1 : cafbt_pkg::HIT_ROLL_F0};
        next_secondId = msgIdent;
      end else if (found1 && !secondBuf[cafbt_pkg::BUF_FULL_BIT]) begin
        next_secondBuf = {msgExtended, 1'b1, code};
        next_secondId = msgIdent;
      end
      // No match: nothing changes
    end

    if (wrEn) begin
      case (paddr)
        cafbt_pkg::OFF_CONTROL: next_control = pwdata[1:0];
        cafbt_pkg::OFF_TIMING: begin
          if (cfgMode) begin
            next_timing = pwdata[18:0];
          end
        end
        cafbt_pkg::OFF_FIRST_BUF: begin
          // Writing 1 to full releases the buffer, unless a message loads it in the same cycle
          if (pwdata[cafbt_pkg::BUF_FULL_BIT] && next_firstBuf == firstBuf) begin
            next_firstBuf[cafbt_pkg::BUF_FULL_BIT] = 1'b0;
          end
        end
        cafbt_pkg::OFF_SECOND_BUF: begin
          if (pwdata[cafbt_pkg::BUF_FULL_BIT] && next_secondBuf == secondBuf) begin
            next_secondBuf[cafbt_pkg::BUF_FULL_BIT] = 1'b0;
          end
        end
        cafbt_pkg::OFF_MASK0: if (cfgMode) next_mask[0] = pwdata[cafbt_pkg::ID_W-1:0];
        cafbt_pkg::OFF_MASK1: if (cfgMode) next_mask[1] = pwdata[cafbt_pkg::ID_W-1:0];
        default: begin
          for (int i = 0; i < NUM_FILTERS; i++) begin
            fOff = cafbt_pkg::OFF_FILTER0 + 8'(4 * i);
            if (paddr == fOff && cfgMode) begin
              next_filter[i] = pwdata[cafbt_pkg::ID_W-1:0];
            end
          end
        end
      endcase
    end

    if (rdEn) begin
      case (paddr)
        cafbt_pkg::OFF_CONTROL: next_prdata = {30'h0000000, control};
        cafbt_pkg::OFF_TIMING: next_prdata = {13'h0000, timing};
        cafbt_pkg::OFF_FIRST_BUF: next_prdata = {27'h0000000, firstBuf};
        cafbt_pkg::OFF_SECOND_BUF: next_prdata = {27'h0000000, secondBuf};
        cafbt_pkg::OFF_FIRST_ID: next_prdata = {3'h0, firstId};
        cafbt_pkg::OFF_SECOND_ID: next_prdata = {3'h0, secondId};
        cafbt_pkg::OFF_STATUS: next_prdata = {29'h0000000, canRxSync, 2'h0};
        cafbt_pkg::OFF_MASK0: if (cfgMode) next_prdata = {3'h0, mask[0]};
        cafbt_pkg::OFF_MASK1: if (cfgMode) next_prdata = {3'h0, mask[1]};
        default: begin
          next_pslverr = 1'b1;
          for (int i = 0; i < NUM_FILTERS; i++) begin
            fOff = cafbt_pkg::OFF_FILTER0 + 8'(4 * i);
            if (paddr == fOff) begin
              next_pslverr = 1'b0;
              if (cfgMode) next_prdata = {3'h0, filter[i]};
            end
          end
        end
      endcase
    end else if (wrEn) begin
      next_pslverr = !(paddr <= cafbt_pkg::OFF_MASK1 ||
        (paddr >= cafbt_pkg::OFF_FILTER0 &&
         paddr < cafbt_pkg::OFF_FILTER0 + 8'(4 * NUM_FILTERS))) || paddr[1:0] != 2'h0
        || paddr == cafbt_pkg::OFF_STATUS + 8'h04;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      control <= cafbt_pkg::CTL_RESET;
      timing <= cafbt_pkg::TIM_RESET;
      mask <= '{default: '0};
      filter <= '{default: '0};
      firstBuf <= 5'h00;
      secondBuf <= 5'h00;
      firstId <= '0;
      secondId <= '0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      control <= next_control;
      timing <= next_timing;
      mask <= next_mask;
      filter <= next_filter;
      firstBuf <= next_firstBuf;
      secondBuf <= next_secondBuf;
      firstId <= next_firstId;
      secondId <= next_secondId;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // Receive pin synchroniser
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rxMeta <= 1'b1;
      canRxSync <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxMeta <= canRx;
      canRxSync <= rxMeta;
      rxPrev <= canRxSync;
    end
  end

  // ==========================================================
  // Bit timing
  logic [5:0] prescaler;
  logic [2:0] propLen;
  logic [2:0] phase1Len;
  logic [2:0] phase2Len;
  logic [6:0] tqCount;
  logic [6:0] next_tqCount;
  logic [2:0] segCount;
  logic [2:0] next_segCount;
  cafbt_pkg::cafbt_seg_t seg;
  cafbt_pkg::cafbt_seg_t next_seg;
  logic next_quantumTick;
  logic next_samplePoint;
  logic next_bitStart;
  logic fallEdge;

  assign prescaler = timing[cafbt_pkg::TIM_PRESCALER_LSB +: 6];
  assign propLen = timing[cafbt_pkg::TIM_PROP_LSB +: 3];
  assign phase1Len = timing[cafbt_pkg::TIM_PHASE1_LSB +: 3];
  // Phase two held to at least two quanta
  assign phase2Len = (timing[cafbt_pkg::TIM_PHASE2_LSB +: 3] < cafbt_pkg::PHASE2_MIN_M1) ?
    cafbt_pkg::PHASE2_MIN_M1 : timing[cafbt_pkg::TIM_PHASE2_LSB +: 3];
  assign fallEdge = rxPrev && !canRxSync;

  always_comb begin
    logic tqEnd;
    tqEnd = (tqCount == {prescaler, 1'b1});
    next_tqCount = tqEnd ? 7'h00 : tqCount + 7'h01;
    next_segCount = segCount;
    next_seg = seg;
    next_quantumTick = tqEnd;
    next_samplePoint = 1'b0;
    next_bitStart = 1'b0;
    if (cfgMode) begin
      next_tqCount = 7'h00;
      next_segCount = 3'h0;
      next_seg = cafbt_pkg::SEG_SYNC;
      next_quantumTick = 1'b0;
    end else if (fallEdge && seg != cafbt_pkg::SEG_SYNC) begin
      // Restart bit so the edge lies in the sync segment
      next_tqCount = 7'h00;
      next_segCount = 3'h0;
      next_seg = cafbt_pkg::SEG_SYNC;
      next_bitStart = 1'b1;
    end else if (tqEnd) begin
      next_segCount = segCount + 3'h1;
      case (seg)
        cafbt_pkg::SEG_SYNC: begin
          next_segCount = 3'h0;
          next_seg = cafbt_pkg::SEG_PROP;
        end
        cafbt_pkg::SEG_PROP: if (segCount == propLen) begin
          next_segCount = 3'h0;
          next_seg = cafbt_pkg::SEG_PHASE1;
        end
        cafbt_pkg::SEG_PHASE1: if (segCount == phase1Len) begin
          next_segCount = 3'h0;
          next_seg = cafbt_pkg::SEG_PHASE2;
          next_samplePoint = 1'b1;
        end
        cafbt_pkg::SEG_PHASE2: if (segCount == phase2Len) begin
          next_segCount = 3'h0;
          next_seg = cafbt_pkg::SEG_SYNC;
          next_bitStart = 1'b1;
        end
        default: next_seg = cafbt_pkg::SEG_SYNC;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tqCount <= 7'h00;
      segCount <= 3'h0;
      seg <= cafbt_pkg::SEG_SYNC;
      quantumTick <= 1'b0;
      samplePoint <= 1'b0;
      bitStart <= 1'b0;
    end else begin
      tqCount <= next_tqCount;
      segCount <= next_segCount;
      seg <= next_seg;
      quantumTick <= next_quantumTick;
      samplePoint <= next_samplePoint;
      bitStart <= next_bitStart;
    end
  end
endmodule // cafbt_top

// ==== tb/cafbt_top_props.sv ====
// Checker: APB answer timing, hidden filter reads and bit timing pulses.
// Assumes it is bound to cafbt_top and sees only its ports.
`timescale 1ns/1ns
module cafbt_top_props #(
  parameter int NUM_FILTERS = 6
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic msgValid,
  input wire logic [cafbt_pkg::ID_W-1:0] msgIdent,
  input wire logic msgExtended,
  input wire logic canRx,
  input wire logic quantumTick,
  input wire logic samplePoint,
  input wire logic bitStart
);
  // ==========================================
  // Mode tracking
  logic cfgMode;
  logic next_cfgMode;
  logic isFilt;
  assign isFilt = paddr >= cafbt_pkg::OFF_MASK0 && paddr < cafbt_pkg::OFF_FILTER0 + 4 * NUM_FILTERS;
  always_comb begin
    next_cfgMode = cfgMode;
    if (psel && penable && pready && pwrite && paddr == cafbt_pkg::OFF_CONTROL) begin
      next_cfgMode = pwdata[0];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgMode <= 1'b1;
    end else begin
      cfgMode <= next_cfgMode;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_read;
    pready && !pwrite;
  endsequence
  property p_answer; s_access |=> pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_hide; s_read ##0 (isFilt && !cfgMode) |-> prdata == 32'h0; endproperty
  property p_cfgread;
    s_read ##0 (paddr == cafbt_pkg::OFF_CONTROL) |-> prdata[0] == cfgMode;
  endproperty
  property p_tick; quantumTick |=> !quantumTick; endproperty
  property p_sync; bitStart |=> !samplePoint [*5]; endproperty
  property p_spgap; samplePoint |=> !samplePoint [*5]; endproperty
  property p_apart; samplePoint |-> !bitStart; endproperty
  a_answer: assert property (p_answer) else $error("no answer after one wait state");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error without ready");
  a_hide: assert property (p_hide) else $error("filter value visible");
  a_cfgread: assert property (p_cfgread) else $error("mode bit wrong");
  a_tick: assert property (p_tick) else $error("quantum shorter than two cycles");
  a_sync: assert property (p_sync) else $error("sample too soon after bit start");
  a_spgap: assert property (p_spgap) else $error("samples too close");
  a_apart: assert property (p_apart) else $error("segments overlap");
endmodule // cafbt_top_props
bind cafbt_top cafbt_top_props #(.NUM_FILTERS(NUM_FILTERS)) i_props (.sys_clk(sys_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .msgValid(msgValid),
  .msgIdent(msgIdent), .msgExtended(msgExtended), .canRx(canRx), .quantumTick(quantumTick),
  .samplePoint(samplePoint), .bitStart(bitStart));

// ==== tb/cafbt_bus_node.sv ====
// Model: another node on the bus, pulls the line dominant on request.
// Assumes a recessive-high line between frames.
`timescale 1ns/1ns
module cafbt_bus_node (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic dropReq,
  output logic canRx
);
  int hold;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      canRx <= 1'b1;
      hold <= 0;
    end else if (dropReq) begin
      canRx <= 1'b0;
      hold <= 7;
    end else if (hold > 0) begin
      hold <= hold - 1;
      if (hold == 1) begin
        canRx <= 1'b1;
      end
    end
  end
endmodule // cafbt_bus_node

// ==== tb/tb_cafbt_top.sv ====
// Testbench: filters, buffers and bit timing through APB and ports.
// Assumes cafbt_top with its checker bound and the bus node model.
`timescale 1ns/1ns
module tb_cafbt_top;
  logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic msgValid = 0, msgExtended = 0, dropReq = 0, pready, pslverr, er;
  logic canRx, quantumTick, samplePoint, bitStart;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [28:0] msgIdent = 0;
  logic [31:0] flt [6] = '{32'h100, 32'h200, 32'h120, 32'h300, 32'h120, 32'h15555550};
  int failures = 0, checks_done = 0, cycles = 0, n;
  cafbt_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .msgValid(msgValid), .msgIdent(msgIdent), .msgExtended(msgExtended),
    .canRx(canRx), .quantumTick(quantumTick), .samplePoint(samplePoint), .bitStart(bitStart));
  cafbt_bus_node i_node (.sys_clk(sys_clk), .reset_n(reset_n), .dropReq(dropReq), .canRx(canRx));
  initial forever #25 sys_clk = ~sys_clk;
  // ==========================================
  // Shared tasks
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    chk(rd, e);
  endtask
  task msg(input logic [28:0] id, input logic x);
    @(posedge sys_clk);
    msgValid <= 1; msgIdent <= id; msgExtended <= x;
    @(posedge sys_clk);
    msgValid <= 0;
    repeat (2) @(posedge sys_clk);
  endtask
  task clr;
    apb(1, cafbt_pkg::OFF_SECOND_BUF, 32'h8);
  endtask
  task waitb;
    do @(posedge sys_clk); while (bitStart !== 1'b1);
  endtask
  // Bit length, quantum spacing, sample point to next bit
  task t_timing(input int nc, input int nq, input int np2);
    int lq, dq, s;
    waitb();
    n = 0; lq = -1; dq = -1; s = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (quantumTick === 1'b1) begin
        if (lq >= 0 && dq < 0) dq = n - lq;
        lq = n;
      end
      if (samplePoint === 1'b1) s = n;
    end while (bitStart !== 1'b1);
    chk(n, nc);
    chk(dq, nq);
    chk(n - s, np2);
  endtask
  // ==========================================
  // Scenarios
  // Reset values and unmapped addresses
  task t_regs;
    rdchk(cafbt_pkg::OFF_CONTROL, 32'h1);
    rdchk(cafbt_pkg::OFF_TIMING, 32'h0);
    apb(0, 8'hFC, 32'h0);
    chk(er, 1'b1);
    apb(1, 8'h1C, 32'h0);
    chk(er, 1'b1);
  endtask
  // Masks, filters and timing, then refused writes outside config
  task t_config;
    apb(1, cafbt_pkg::OFF_CONTROL, 32'h1);
    apb(1, cafbt_pkg::OFF_TIMING, 32'h00004001);
    apb(1, cafbt_pkg::OFF_MASK0, 32'h7FF);
    apb(1, cafbt_pkg::OFF_MASK1, 32'h1FFFFFF0);
    for (int i = 0; i < 6; i++) apb(1, cafbt_pkg::OFF_FILTER0 + 8'(4 * i), flt[i]);
    rdchk(cafbt_pkg::OFF_FILTER0 + 8'hC, 32'h300);
    apb(1, cafbt_pkg::OFF_CONTROL, 32'h0);
    rdchk(cafbt_pkg::OFF_MASK1, 32'h0);
    rdchk(cafbt_pkg::OFF_FILTER0, 32'h0);
    apb(1, cafbt_pkg::OFF_FILTER0 + 8'h8, 32'h7FF);
    apb(1, cafbt_pkg::OFF_TIMING, 32'h0);
  endtask
  // Falling edge mid-bit restarts the bit
  task t_resync;
    waitb();
    repeat (10) @(posedge sys_clk);
    dropReq <= 1;
    @(posedge sys_clk);
    dropReq <= 0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (bitStart !== 1'b1 && n < 40);
    chk(n <= 8, 1'b1);
  endtask
  // Buffer one filters, priority and identifier width
  task t_filters;
    msg(29'h12B, 0);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h0A);
    rdchk(cafbt_pkg::OFF_SECOND_ID, 32'h12B);
    clr();
    msg(29'h3F1, 0);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h02);
    msg(29'h15555557, 1);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h1D);
    clr();
    msg(29'h05555557, 1);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h15);
  endtask
  // Buffer zero and rollover codes
  task t_rollover;
    msg(29'h100, 0);
    rdchk(cafbt_pkg::OFF_FIRST_ID, 32'h100);
    apb(0, cafbt_pkg::OFF_FIRST_BUF, 32'h0);
    chk(rd[cafbt_pkg::BUF_FULL_BIT], 1'b1);
    msg(29'h200, 0);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h15);
    apb(1, cafbt_pkg::OFF_CONTROL, 32'h2);
    msg(29'h200, 0);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h0F);
    clr();
    msg(29'h100, 0);
    rdchk(cafbt_pkg::OFF_SECOND_BUF, 32'h0E);
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    t_regs();
    apb(1, cafbt_pkg::OFF_TIMING, 32'h00077700);
    apb(1, cafbt_pkg::OFF_CONTROL, 32'h0);
    t_timing(50, 2, 16);
    t_config();
    t_timing(36, 4, 8);
    t_resync();
    t_filters();
    t_rollover();
    end_sim();
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
endmodule // tb_cafbt_top
